/* File: pkg/cgrf_pkg.sv */
// constants for the co2 recalibration and noise-filter control block
// assumes a 32-bit classic wishbone slave with one word per register
package cgrf_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_CTRL_CODE = 8'h00;
	localparam logic [7:0] OFF_RAW_IN = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_CONC_UNFILT = 8'h0c;
	localparam logic [7:0] OFF_CONC_FILT = 8'h10;
	localparam logic [7:0] OFF_OFFSET = 8'h14;
	localparam logic [7:0] OFF_BASELINE = 8'h18;
	localparam logic [7:0] OFF_ABC_STEP = 8'h1c;
	localparam logic [7:0] OFF_BIG_STEP = 8'h20;
	localparam logic [7:0] OFF_STABLE_LIM = 8'h24;
	localparam logic [7:0] OFF_TARGET = 8'h8e;
	// ==========================================================
	// calculation control codes
	localparam logic [7:0] CODE_TGT_UNF = 8'h30;
	localparam logic [7:0] CODE_TGT_FLT = 8'h31;
	localparam logic [7:0] CODE_TGT_UNF_RST = 8'h32;
	localparam logic [7:0] CODE_TGT_FLT_RST = 8'h33;
	localparam logic [7:0] CODE_ABC = 8'h70;
	localparam logic [7:0] CODE_ABC_RST = 8'h72;
	// ==========================================================
	// reset values and constants
	localparam logic [15:0] FRESH_AIR_PPM = 16'h0190;
	localparam logic [15:0] RST_ABC_STEP = 16'h0032;
	localparam logic [15:0] RST_BIG_STEP = 16'h0064;
	localparam logic [15:0] RST_STABLE_LIM = 16'h0014;
	localparam logic [15:0] RST_TARGET = 16'h0190;
	localparam logic [15:0] RST_BASELINE = 16'hffff;
	// status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_VALID = 1;
	localparam int ST_LAST_BIG = 2;
	localparam int ST_STABLE = 3;
	localparam int ST_CAL_DONE = 4;
	typedef enum logic [1:0]
	{
		CGRF_IDLE = 2'b00,
		CGRF_FILT = 2'b01,
		CGRF_CAL = 2'b10,
		CGRF_DONE = 2'b11
	} cgrf_state_e;
endpackage

/* File: src/cgrf_core.sv */
// co2 recalibration and noise-filter control, wishbone slave
// assumes signal and concentration share one ppm-equivalent scale
//
// Notes on behaviour
// - code 0x70 sets offset from stored lowest baseline as 400 ppm, filtered.
// - code 0x72 does 0x70 then resets filter memory to raw value.
// - baseline replaced only by lower filtered signal in stable environment.
// - per-cycle baseline offset change is clamped to a maximum step.
// - code 0x30 offset from unfiltered signal versus target concentration.
// - code 0x31 offset from filtered signal versus target concentration.
// - codes 0x32, 0x33 as 0x30, 0x31 plus filter reset.
// - filter is dynamic iir passing a fraction of each step.
// - large step passes one half.
// - small step passes one sixth.
// - filter reset loads filter memory with current raw value.
// - filtered and unfiltered results computed in parallel from raw.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
module cgrf_core
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic [15:0] conc_unfilt_o,
	output logic [15:0] conc_filt_o,
	output logic period_done_o
);
	// ==========================================================
	// bus access
	logic req;
	logic wr_acc;
	logic [15:0] wr16;
	assign req = cyc_i && stb_i && !ack_o;
	assign wr_acc = req && we_i;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	logic [7:0] code_reg;
	logic [15:0] raw_in_reg;
	logic [15:0] target_reg;
	logic [15:0] abc_step_reg;
	logic [15:0] big_step_reg;
	logic [15:0] stable_lim_reg;
	logic start_reg;
	cgrf_pkg::cgrf_state_e state_reg;
	logic [15:0] filt_mem_reg;
	logic [15:0] baseline_reg;
	logic signed [16:0] offset_reg;
	logic valid_reg;
	logic last_big_reg;
	logic stable_reg;
	logic cal_done_reg;
	logic busy;

	// a period counts as running from the raw write on
	assign busy = start_reg || state_reg != cgrf_pkg::CGRF_IDLE;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= req;
	end

	// writing the raw register while not busy starts one measurement period
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			code_reg <= 8'h00;
			raw_in_reg <= 16'h0000;
			target_reg <= cgrf_pkg::RST_TARGET;
			abc_step_reg <= cgrf_pkg::RST_ABC_STEP;
			big_step_reg <= cgrf_pkg::RST_BIG_STEP;
			stable_lim_reg <= cgrf_pkg::RST_STABLE_LIM;
			start_reg <= 1'b0;
		end
		else
		begin
			start_reg <= 1'b0;
			if (state_reg == cgrf_pkg::CGRF_DONE)
				code_reg <= 8'h00;
			if (wr_acc && !busy)
			begin
				if (hit(adr_i, cgrf_pkg::OFF_CTRL_CODE) && sel_i[0])
					code_reg <= dat_i[7:0];
				if (hit(adr_i, cgrf_pkg::OFF_RAW_IN))
				begin
					raw_in_reg <= merge16(raw_in_reg, dat_i, sel_i);
					start_reg <= 1'b1;
				end
			end
			if (wr_acc)
			begin
				if (hit(adr_i, cgrf_pkg::OFF_TARGET))
					target_reg <= merge16(target_reg, dat_i, sel_i);
				if (hit(adr_i, cgrf_pkg::OFF_ABC_STEP))
					abc_step_reg <= merge16(abc_step_reg, dat_i, sel_i);
				if (hit(adr_i, cgrf_pkg::OFF_BIG_STEP))
					big_step_reg <= merge16(big_step_reg, dat_i, sel_i);
				if (hit(adr_i, cgrf_pkg::OFF_STABLE_LIM))
					stable_lim_reg <= merge16(stable_lim_reg, dat_i, sel_i);
			end
		end
	end

	// ==========================================================
	// code decode
	logic is_abc;
	logic is_tgt;
	logic use_filt;
	logic do_reset;
	always_comb
	begin
		is_abc = 1'b0;
		is_tgt = 1'b0;
		use_filt = 1'b0;
		do_reset = 1'b0;
		case (code_reg)
			cgrf_pkg::CODE_ABC:
			begin
				is_abc = 1'b1;
				use_filt = 1'b1;
			end
			cgrf_pkg::CODE_ABC_RST:
			begin
				is_abc = 1'b1;
				use_filt = 1'b1;
				do_reset = 1'b1;
			end
			cgrf_pkg::CODE_TGT_UNF: is_tgt = 1'b1;
			cgrf_pkg::CODE_TGT_FLT:
			begin
				is_tgt = 1'b1;
				use_filt = 1'b1;
			end
			cgrf_pkg::CODE_TGT_UNF_RST:
			begin
				is_tgt = 1'b1;
				do_reset = 1'b1;
			end
			cgrf_pkg::CODE_TGT_FLT_RST:
			begin
				is_tgt = 1'b1;
				use_filt = 1'b1;
				do_reset = 1'b1;
			end
			default: ;
		endcase
	end

	// ==========================================================
	// iir filter step
	logic signed [16:0] step;
	logic [15:0] step_abs;
	logic big;
	logic signed [16:0] frac;
	logic [15:0] filt_new;
	always_comb
	begin
		step = $signed({1'b0, raw_in_reg}) - $signed({1'b0, filt_mem_reg});
		// first period after reset seeds the filter with raw
		step_abs = step[16] ? 16'(-step) : step[15:0];
		big = step_abs >= big_step_reg;
		if (big)
			frac = step >>> 1;
		else
			frac = 17'(step / 17'sd6);
		filt_new = valid_reg ? 16'(filt_mem_reg + frac[15:0]) : raw_in_reg;
	end

	// ==========================================================
	// calibration arithmetic
	logic signed [16:0] ref_sig;
	logic signed [16:0] cal_want;
	logic signed [17:0] cal_delta;
	logic signed [17:0] step_lim;
	logic signed [16:0] abc_next;
	always_comb
	begin
		ref_sig = use_filt ? $signed({1'b0, filt_mem_reg}) : $signed({1'b0, raw_in_reg});
		if (is_abc)
			cal_want = $signed({1'b0, cgrf_pkg::FRESH_AIR_PPM}) - $signed({1'b0, baseline_reg});
		else
			cal_want = $signed({1'b0, target_reg}) - ref_sig;
		// extra bit: want and offset may lie a full range apart
		cal_delta = $signed({cal_want[16], cal_want}) - $signed({offset_reg[16], offset_reg});
		step_lim = $signed({2'b00, abc_step_reg});
		if (cal_delta > step_lim)
			abc_next = offset_reg + $signed(step_lim[16:0]);
		else if (cal_delta < -step_lim)
			abc_next = offset_reg - $signed(step_lim[16:0]);
		else
			abc_next = cal_want;
	end

	// ==========================================================
	// sequencer
	// fixed four-state walk, one period per raw write accepted while not busy
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_reg <= cgrf_pkg::CGRF_IDLE;
		else
		begin
			case (state_reg)
				cgrf_pkg::CGRF_IDLE:
					if (start_reg)
						state_reg <= cgrf_pkg::CGRF_FILT;
				cgrf_pkg::CGRF_FILT: state_reg <= cgrf_pkg::CGRF_CAL;
				cgrf_pkg::CGRF_CAL: state_reg <= cgrf_pkg::CGRF_DONE;
				cgrf_pkg::CGRF_DONE: state_reg <= cgrf_pkg::CGRF_IDLE;
				default: state_reg <= cgrf_pkg::CGRF_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			filt_mem_reg <= 16'h0000;
			valid_reg <= 1'b0;
			last_big_reg <= 1'b0;
			stable_reg <= 1'b0;
		end
		else if (state_reg == cgrf_pkg::CGRF_FILT)
		begin
			filt_mem_reg <= filt_new;
			valid_reg <= 1'b1;
			last_big_reg <= big;
			stable_reg <= valid_reg && (step_abs <= stable_lim_reg);
		end
		else if (state_reg == cgrf_pkg::CGRF_DONE && do_reset)
			filt_mem_reg <= raw_in_reg;
	end

	// baseline tracks lowest stable filtered signal
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			baseline_reg <= cgrf_pkg::RST_BASELINE;
		else if (state_reg == cgrf_pkg::CGRF_CAL && stable_reg && filt_mem_reg < baseline_reg)
			baseline_reg <= filt_mem_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			offset_reg <= 17'sd0;
			cal_done_reg <= 1'b0;
		end
		else if (state_reg == cgrf_pkg::CGRF_CAL)
		begin
			cal_done_reg <= is_abc || is_tgt;
			if (is_abc)
				offset_reg <= abc_next;
			else if (is_tgt)
				offset_reg <= cal_want;
		end
	end

	// ==========================================================
	// results, computed side by side
	// reset codes present raw through the filter path
	logic [15:0] filt_shown;
	assign filt_shown = do_reset ? raw_in_reg : filt_mem_reg;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			conc_unfilt_o <= 16'h0000;
			conc_filt_o <= 16'h0000;
			period_done_o <= 1'b0;
		end
		else
		begin
			period_done_o <= state_reg == cgrf_pkg::CGRF_DONE;
			if (state_reg == cgrf_pkg::CGRF_DONE)
			begin
				conc_unfilt_o <= 16'($signed({1'b0, raw_in_reg}) + offset_reg);
				conc_filt_o <= 16'($signed({1'b0, filt_shown}) + offset_reg);
			end
		end
	end

	// ==========================================================
	// status word
	logic [31:0] status_word;
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[cgrf_pkg::ST_BUSY] = busy;
		status_word[cgrf_pkg::ST_VALID] = valid_reg;
		status_word[cgrf_pkg::ST_LAST_BIG] = last_big_reg;
		status_word[cgrf_pkg::ST_STABLE] = stable_reg;
		status_word[cgrf_pkg::ST_CAL_DONE] = cal_done_reg;
	end

	// ==========================================================
	// read mux
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (req && !we_i)
		begin
			case (adr_i)
				cgrf_pkg::OFF_CTRL_CODE: dat_o <= {24'h000000, code_reg};
				cgrf_pkg::OFF_RAW_IN: dat_o <= {16'h0000, raw_in_reg};
				cgrf_pkg::OFF_STATUS: dat_o <= status_word;
				cgrf_pkg::OFF_CONC_UNFILT: dat_o <= {16'h0000, conc_unfilt_o};
				cgrf_pkg::OFF_CONC_FILT: dat_o <= {16'h0000, conc_filt_o};
				cgrf_pkg::OFF_OFFSET: dat_o <= {{15{offset_reg[16]}}, offset_reg};
				cgrf_pkg::OFF_BASELINE: dat_o <= {16'h0000, baseline_reg};
				cgrf_pkg::OFF_ABC_STEP: dat_o <= {16'h0000, abc_step_reg};
				cgrf_pkg::OFF_BIG_STEP: dat_o <= {16'h0000, big_step_reg};
				cgrf_pkg::OFF_STABLE_LIM: dat_o <= {16'h0000, stable_lim_reg};
				cgrf_pkg::OFF_TARGET: dat_o <= {16'h0000, target_reg};
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule

/* File: test/cgrf_host.sv */
// host model: classic wishbone master
// assumes the bench watchdog bounds every wait for ack
`timescale 1ns/10ps
module cgrf_host
(
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	initial
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	// one request held until ack, then released for a cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, d};
		do
			@(posedge clk_i);
		while (ack_i !== 1'b1);
		q = dat_i;
		{cyc_o, stb_o, we_o, dat_o} <= {3'b000, ~d};
	endtask
endmodule

/* File: test/cgrf_monitor.sv */
// port checker for cgrf_core
// assumes binding into cgrf_core, one clock
`timescale 1ns/10ps
module cgrf_monitor
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [15:0] conc_unfilt_o,
	input wire logic [15:0] conc_filt_o,
	input wire logic period_done_o
);
	// ==========================================================
	// code seen by the running period
	logic [7:0] code_reg;
	always_ff @(posedge clk_i)
		if (rst_i || period_done_o)
			code_reg <= 8'h00;
		else if (ack_o && we_i && adr_i == cgrf_pkg::OFF_CTRL_CODE)
			code_reg <= dat_i[7:0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence raw_taken;
		cyc_i && stb_i && we_i && !ack_o && adr_i == cgrf_pkg::OFF_RAW_IN;
	endsequence
	sequence reset_done;
		period_done_o && code_reg inside {8'h32, 8'h33, 8'h72};
	endsequence
	ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	ack_prompt_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
	done_pulse_a: assert property (period_done_o |=> !period_done_o) else $error("done not a pulse");
	raw_period_a: assert property (raw_taken ##1 ack_o |-> ##[2:12] period_done_o)
		else $error("period did not end");
	out_hold_a: assert property (!period_done_o |-> $stable(conc_unfilt_o) && $stable(conc_filt_o))
		else $error("result moved outside period end");
	filt_reset_a: assert property (reset_done |-> conc_filt_o == conc_unfilt_o)
		else $error("filter not reset to raw");
	unmapped_read_a: assert property (ack_o && !we_i && adr_i == 8'h40 |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule

/* File: test/testbench.sv */
// self-checking bench for cgrf_core
// assumes host model and monitor files
`timescale 1ns/10ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i, stb_i, we_i, ack_o, period_done_o;
	logic [7:0] adr_i;
	logic [7:0] lf = 8'h26;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q, off0;
	logic signed [31:0] d;
	logic [15:0] conc_unfilt_o, conc_filt_o;
	logic [32:0] expq[$];
	logic [32:0] e;
	logic [7:0] offs[4] = '{cgrf_pkg::OFF_ABC_STEP, cgrf_pkg::OFF_BIG_STEP, cgrf_pkg::OFF_STABLE_LIM, 8'h40};
	logic [15:0] rv[4] = '{cgrf_pkg::RST_ABC_STEP, cgrf_pkg::RST_BIG_STEP, cgrf_pkg::RST_STABLE_LIM, 16'h0};
	int failures = 0;
	int n_checks = 0;
	always #12.5 clk_i = ~clk_i;
	cgrf_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .conc_unfilt_o(conc_unfilt_o),
		.conc_filt_o(conc_filt_o), .period_done_o(period_done_o));
	cgrf_host host_u (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
		.adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// eq set: only filtered equal to unfiltered is known; one call per measurement period
	task automatic period(input logic [7:0] code, input logic [15:0] raw, input logic eq, input logic [31:0] ex);
		expq.push_back({eq, ex});
		host_u.xfer(1'b1, cgrf_pkg::OFF_CTRL_CODE, {24'h0, code}, q);
		host_u.xfer(1'b1, cgrf_pkg::OFF_RAW_IN, {16'h0, raw}, q);
		while (period_done_o !== 1'b1)
			@(posedge clk_i);
		@(posedge clk_i);
	endtask
	// correction issued whenever the host chooses
	task automatic abc_step(input logic [7:0] code);
		host_u.xfer(1'b0, cgrf_pkg::OFF_OFFSET, 32'h0, off0);
		period(code, 16'd1420, 1'b1, 32'h0);
		host_u.xfer(1'b0, cgrf_pkg::OFF_OFFSET, 32'h0, q);
		d = q - off0;
		chk(d, -{16'h0, cgrf_pkg::RST_ABC_STEP});
	endtask
	always @(posedge clk_i)
		if (period_done_o === 1'b1)
		begin
			e = expq.size() > 0 ? expq.pop_front() : 33'h0_dead_beef;
			if (e[32])
				chk({16'h0, conc_filt_o}, {16'h0, conc_unfilt_o});
			else
				chk({conc_unfilt_o, conc_filt_o}, e[31:0]);
		end
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		lf = lfsr(lf);
		host_u.xfer(1'b1, 8'h40, {4{lf}}, q);
		foreach (offs[i])
		begin
			host_u.xfer(1'b0, offs[i], 32'h0, q);
			chk(q, {16'h0, rv[i]});
		end
		host_u.xfer(1'b0, cgrf_pkg::OFF_TARGET, 32'h0, q);
		chk(q, {16'h0, cgrf_pkg::RST_TARGET});
		period(8'h00, 16'd1000, 1'b0, {16'd1000, 16'd1000});
		period(8'h00, 16'd1060, 1'b0, {16'd1060, 16'd1010});
		period(8'h00, 16'd1260, 1'b0, {16'd1260, 16'd1135});
		host_u.xfer(1'b1, cgrf_pkg::OFF_TARGET, 32'd500, q);
		period(cgrf_pkg::CODE_TGT_UNF_RST, 16'd1300, 1'b0, {16'd500, 16'd500});
		period(8'h00, 16'd1300, 1'b0, {16'd500, 16'd500});
		host_u.xfer(1'b1, cgrf_pkg::OFF_TARGET, 32'd600, q);
		period(cgrf_pkg::CODE_TGT_FLT, 16'd1360, 1'b0, {16'd650, 16'd600});
		period(cgrf_pkg::CODE_TGT_UNF, 16'd1360, 1'b0, {16'd600, 16'd558});
		period(cgrf_pkg::CODE_TGT_FLT_RST, 16'd1420, 1'b0, {16'd651, 16'd651});
		period(8'h55, 16'd1420, 1'b0, {16'd651, 16'd651});
		host_u.xfer(1'b0, cgrf_pkg::OFF_BASELINE, 32'h0, q);
		chk(q, {16'h0, 16'd1300});
		abc_step(cgrf_pkg::CODE_ABC_RST);
		abc_step(cgrf_pkg::CODE_ABC);
		chk(32'(expq.size()), 32'h0);
		results();
	end
	initial
	begin
		#100us;
		failures++;
		results();
	end
endmodule
bind cgrf_core cgrf_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .conc_unfilt_o(conc_unfilt_o),
	.conc_filt_o(conc_filt_o), .period_done_o(period_done_o));
